// ### tag_ctrl.sv
// Host controller driving the cache-tag memory through its pins.
`timescale 1ns/1ps
`default_nettype none
module tag_ctrl (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Command port.
   input wire logic req_i,
   input wire logic [1:0] op_i,
   input wire logic [tag_ctrl_pkg::ADDR_W-1:0] addr_i,
   input wire logic [tag_ctrl_pkg::DATA_W-1:0] wdata_i,
   output logic ready_o,
   output logic done_o,
   output logic [tag_ctrl_pkg::DATA_W-1:0] rdata_o,
   output logic hit_o,
   // Device pins.
   output logic [tag_ctrl_pkg::ADDR_W-1:0] mem_addr_o,
   output logic [tag_ctrl_pkg::DATA_W-1:0] mem_data_o,
   output logic mem_data_oe_n_o,
   input wire logic [tag_ctrl_pkg::DATA_W-1:0] mem_data_i,
   output logic mem_cs_n_o,
   output logic mem_we_n_o,
   output logic mem_oe_n_o,
   output logic mem_clear_n_o,
   input wire logic match_i
);
   import tag_ctrl_pkg::*;

   // =========================================================
   // State
   typedef struct packed {
      phase_t phase;
      logic [1:0] op;
      logic [CNT_W-1:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic data_oe_n;
      logic cs_n;
      logic we_n;
      logic oe_n;
      logic clear_n;
      logic ready;
      logic done;
      logic [DATA_W-1:0] rdata;
      logic hit;
      logic [DATA_W-1:0] din_s1;
      logic [DATA_W-1:0] din_s2;
      logic match_s1;
      logic match_s2;
   } state_t;
   state_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.cnt = (s_reg.cnt == '0) ? '0 : s_reg.cnt - 1'b1;
      // Two flops on each pin input; only the second one is read.
      s_next.din_s1 = mem_data_i;
      s_next.din_s2 = s_reg.din_s1;
      s_next.match_s1 = match_i;
      s_next.match_s2 = s_reg.match_s1;
      unique case (s_reg.phase)
         ST_IDLE: begin
            if (req_i) begin
               // Address moves only with both strobes high.
               s_next.addr = addr_i;
               s_next.data = wdata_i;
               s_next.op = op_i;
               s_next.ready = 1'b0;
               s_next.phase = ST_SETUP;
            end
         end
         ST_SETUP: begin
            s_next.phase = ST_STROBE;
            unique case (s_reg.op)
               OP_READ: begin
                  s_next.cs_n = 1'b0;
                  s_next.oe_n = 1'b0;
                  s_next.cnt = CNT_W'(ACCESS_CYC);
               end
               OP_WRITE: begin
                  // Data enable falls with both strobes, so the pins are never left floating.
                  s_next.data_oe_n = 1'b0;
                  s_next.cs_n = 1'b0;
                  s_next.we_n = 1'b0;
                  s_next.cnt = CNT_W'(WRITE_CYC);
               end
               OP_COMPARE: begin
                  s_next.data_oe_n = 1'b0;
                  s_next.cs_n = 1'b0;
                  s_next.cnt = CNT_W'(ACCESS_CYC);
               end
               OP_CLEAR: begin
                  s_next.clear_n = 1'b0;
                  s_next.cnt = CNT_W'(CLR_CYC);
               end
            endcase
         end
         ST_STROBE: begin
            if (s_reg.cnt == '0) begin
               s_next.phase = ST_WAIT;
               s_next.cnt = CNT_W'(SYNC_CYC);
            end
         end
         ST_WAIT: begin
            // Three extra cycles (SYNC_CYC plus one) cover the pin synchronisers.
            if (s_reg.cnt == '0) begin
               s_next.phase = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (s_reg.op == OP_READ) begin
               s_next.rdata = s_reg.din_s2;
            end
            if (s_reg.op == OP_COMPARE) begin
               s_next.hit = s_reg.match_s2;
            end
            s_next.cs_n = 1'b1;
            s_next.we_n = 1'b1;
            s_next.oe_n = 1'b1;
            s_next.clear_n = 1'b1;
            s_next.cnt = CNT_W'(RECOV_CYC);
            s_next.phase = ST_RECOVER;
         end
         ST_RECOVER: begin
            // Release data only after strobes; keeps inputs driven meanwhile.
            s_next.data_oe_n = 1'b1;
            if (s_reg.cnt == '0) begin
               s_next.done = 1'b1;
               s_next.ready = 1'b1;
               s_next.phase = ST_IDLE;
            end
         end
         default: s_next.phase = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_reg <= '{phase: ST_IDLE, op: OP_READ, cnt: '0, addr: '0,
                    data: '0, data_oe_n: 1'b1, cs_n: 1'b1, we_n: 1'b1,
                    oe_n: 1'b1, clear_n: 1'b1, ready: 1'b1, done: 1'b0,
                    rdata: '0, hit: 1'b0, din_s1: '0, din_s2: '0,
                    match_s1: 1'b1, match_s2: 1'b1};
      end else begin
         s_reg <= s_next;
      end
   end

   assign ready_o = s_reg.ready;
   assign done_o = s_reg.done;
   assign rdata_o = s_reg.rdata;
   assign hit_o = s_reg.hit;
   assign mem_addr_o = s_reg.addr;
   assign mem_data_o = s_reg.data;
   assign mem_data_oe_n_o = s_reg.data_oe_n;
   assign mem_cs_n_o = s_reg.cs_n;
   assign mem_we_n_o = s_reg.we_n;
   assign mem_oe_n_o = s_reg.oe_n;
   assign mem_clear_n_o = s_reg.clear_n;

   // =========================================================
   // Assertions
   a_addr_stable: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !$stable(mem_addr_o) |-> mem_we_n_o && mem_cs_n_o)
      else $error("address changed with a strobe active");
   a_no_contention: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !mem_oe_n_o && mem_we_n_o |-> mem_data_oe_n_o)
      else $error("host drove data during a device read");
   a_write_pair: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $fell(mem_we_n_o) |-> $fell(mem_cs_n_o) && !mem_data_oe_n_o)
      else $error("write strobe fell without select and data");
   a_clear_width: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $fell(mem_clear_n_o) |-> !mem_clear_n_o [*7])
      else $error("clear pulse too short");
   a_clear_recov: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(mem_clear_n_o) |-> mem_we_n_o [*2])
      else $error("write strobe too soon after clear");
   a_write_width: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $fell(mem_we_n_o) |-> !mem_we_n_o [*4])
      else $error("write pulse too short");
   a_done_ready: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      done_o |-> ready_o && mem_cs_n_o && mem_data_oe_n_o)
      else $error("done without idle pins");
   a_cmp_oe_high: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !mem_cs_n_o && !mem_data_oe_n_o && mem_we_n_o |-> mem_oe_n_o)
      else $error("output enable low during compare");
   a_read_quiet: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !mem_oe_n_o |-> mem_data_oe_n_o && mem_we_n_o && mem_clear_n_o)
      else $error("host active on the pins during a read");
   a_data_driven: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !mem_cs_n_o |-> !mem_data_oe_n_o || !mem_oe_n_o)
      else $error("data pins left floating while selected");
   a_clear_quiet: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !mem_clear_n_o |-> mem_we_n_o && mem_cs_n_o)
      else $error("strobe active during clear");
   a_write_hold: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !mem_we_n_o |-> !mem_data_oe_n_o && $stable(mem_addr_o)
         && $stable(mem_data_o))
      else $error("address or data moved during a write");
   a_done_pulse: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      done_o |=> !done_o)
      else $error("done longer than one cycle");
   a_idle_pins: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      ready_o |-> mem_cs_n_o && mem_we_n_o && mem_clear_n_o)
      else $error("strobe active while idle");
   a_match_sync: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !$stable(hit_o) |-> !$past(mem_cs_n_o) && !$past(mem_data_oe_n_o)
         && $past(mem_oe_n_o))
      else $error("hit changed outside a compare");

   // Covers for the main scenarios.
   c_write: cover property (@(posedge clk_i) $fell(mem_we_n_o));
   c_clear: cover property (@(posedge clk_i) $fell(mem_clear_n_o));
   c_hit: cover property (@(posedge clk_i) $rose(hit_o));
   c_miss: cover property (@(posedge clk_i) $fell(hit_o));
   c_read: cover property (@(posedge clk_i) $fell(mem_oe_n_o));
endmodule : tag_ctrl
`default_nettype wire

// ### tag_ctrl_pkg.sv
// Constants and types for the cache-tag memory controller.
package tag_ctrl_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 9;
   localparam int CLK_PERIOD_PS = 4000;
   // Times in picoseconds, cycle counts rounded as their kind requires.
   localparam int CLR_PULSE_PS = 25000;
   localparam int CLR_RECOV_PS = 3000;
   localparam int WRITE_PULSE_PS = 15000;
   localparam int ACCESS_PS = 25000;
   localparam int CLR_CYC =
      (CLR_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RECOV_CYC =
      (CLR_RECOV_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRITE_CYC =
      (WRITE_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACCESS_CYC =
      (ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Extra cycles that let the two-flop pin synchronisers settle.
   localparam int SYNC_CYC = 2;
   localparam int CNT_W = 4;
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_COMPARE = 2'h2;
   localparam logic [1:0] OP_CLEAR = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_STROBE, ST_WAIT, ST_SAMPLE, ST_RECOVER
   } phase_t;
endpackage : tag_ctrl_pkg

// ### tag_ram_model.sv
// Behavioural model of the cache-tag memory and its comparator.
`timescale 1ns/1ps
`default_nettype none
module tag_ram_model (
   // Pins from the host.
   input wire logic [12:0] addr_i,
   input wire logic [8:0] host_data_i,
   input wire logic host_oe_n_i,
   input wire logic cs_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic clear_n_i,
   // Resolved data bus and open-drain flag.
   output logic [8:0] bus_o,
   output logic match_o
);
   logic [8:0] mem [0:8191];
   logic [8:0] last = 9'h000;
   logic drv;
   assign drv = !cs_n_i && we_n_i && !oe_n_i;
   // A released bus shows the inverse of its last level, never a held value.
   always @* begin
      if (drv) bus_o = mem[addr_i];
      else if (!host_oe_n_i) bus_o = host_data_i;
      else bus_o = ~last;
   end
   always @(bus_o) if (drv || !host_oe_n_i) last = bus_o;
   always @* if (!cs_n_i && !we_n_i && clear_n_i) mem[addr_i] = bus_o;
   always @(negedge clear_n_i) begin
      for (int i = 0; i < 8192; i++) mem[i] = 9'h000;
   end
   // Pulled low only on a mismatch; the external pull-up gives high.
   assign match_o = (cs_n_i || !oe_n_i || !we_n_i || !clear_n_i)
      ? 1'b1
      : (mem[addr_i] == bus_o);
endmodule : tag_ram_model
`default_nettype wire

// ### tag_ctrl_bench.sv
// Self-checking bench for the cache-tag memory controller.
`timescale 1ns/1ps
`default_nettype none
module tag_ctrl_bench;
   import tag_ctrl_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic req_i = 1'b0;
   logic [1:0] op_i = 2'h0;
   logic [ADDR_W-1:0] addr_i = 13'h0000;
   logic [DATA_W-1:0] wdata_i = 9'h000;
   logic ready_o, done_o, hit_o, data_oe_n, cs_n, we_n, oe_n, clear_n, match;
   logic [DATA_W-1:0] rdata_o, data_out, bus;
   logic [ADDR_W-1:0] mem_addr;
   logic [ADDR_W-1:0] prev_addr = 13'h0000;
   int n_errors = 0;
   int total_checks = 0;
   int clr_len = 0;
   // Edges from the take edge until done is seen: setup, strobe count
   // plus one, synchroniser wait plus one, sample, recovery plus one and
   // the edge at which the bench looks.
   localparam int RD_LAT = ACCESS_CYC + SYNC_CYC + RECOV_CYC + 6;
   localparam int WR_LAT = WRITE_CYC + SYNC_CYC + RECOV_CYC + 6;
   localparam int CLR_LAT = CLR_CYC + SYNC_CYC + RECOV_CYC + 6;
   always #2 clk_i = ~clk_i;
   tag_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
      .op_i(op_i), .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
      .done_o(done_o), .rdata_o(rdata_o), .hit_o(hit_o),
      .mem_addr_o(mem_addr), .mem_data_o(data_out),
      .mem_data_oe_n_o(data_oe_n), .mem_data_i(bus), .mem_cs_n_o(cs_n),
      .mem_we_n_o(we_n), .mem_oe_n_o(oe_n), .mem_clear_n_o(clear_n),
      .match_i(match));
   tag_ram_model dev (.addr_i(mem_addr), .host_data_i(data_out),
      .host_oe_n_i(data_oe_n), .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n),
      .clear_n_i(clear_n), .bus_o(bus), .match_o(match));
   task automatic fail(input string msg);
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask : fail
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) fail(msg);
   endtask : check
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // Pin-level watch over the whole run.
   always @(posedge clk_i) begin
      if (rst_n_i && mem_addr !== prev_addr && !(cs_n && we_n))
         fail("address moved while strobed");
      if (!data_oe_n && !cs_n && we_n && !oe_n)
         fail("bus contention");
      if (rst_n_i && clear_n === 1'b1 && clr_len > 0 && clr_len < 7)
         fail("clear pulse short");
      clr_len <= (clear_n === 1'b0) ? clr_len + 1 : 0;
      prev_addr <= mem_addr;
   end
   task automatic run_op(input logic [1:0] op, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d, input int lat);
      int k;
      k = 0;
      @(posedge clk_i);
      req_i <= 1'b1;
      op_i <= op;
      addr_i <= a;
      wdata_i <= d;
      do begin
         @(posedge clk_i);
         k++;
         if (k > 40) begin
            fail("request not taken");
            final_report();
         end
      end while (ready_o !== 1'b1);
      req_i <= 1'b0;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
         if (k > 40) begin
            fail("no completion");
            final_report();
         end
      end while (done_o !== 1'b1);
      check(k == lat, "completion latency");
      check(ready_o === 1'b1, "not ready at completion");
   endtask : run_op
   logic [ADDR_W-1:0] adr [4] = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1555};
   logic [DATA_W-1:0] dat [4] = '{9'h1FF, 9'h001, 9'h155, 9'h100};
   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      run_op(OP_CLEAR, 13'h0000, 9'h000, CLR_LAT);
      run_op(OP_READ, 13'h1FFF, 9'h1FF, RD_LAT);
      check(rdata_o === 9'h000, "word not cleared");
      for (int i = 0; i < 4; i++) begin
         run_op(OP_WRITE, adr[i], dat[i], WR_LAT);
         run_op(OP_READ, adr[i], 9'h000, RD_LAT);
         check(rdata_o === dat[i], "read back");
      end
      run_op(OP_COMPARE, 13'h0AAA, 9'h155, RD_LAT);
      check(hit_o === 1'b1, "compare hit");
      run_op(OP_COMPARE, 13'h0AAA, 9'h055, RD_LAT);
      check(hit_o === 1'b0, "top bit miss");
      run_op(OP_COMPARE, 13'h1555, 9'h100, RD_LAT);
      check(hit_o === 1'b1, "new address hit");
      run_op(OP_CLEAR, 13'h0000, 9'h000, CLR_LAT);
      run_op(OP_COMPARE, 13'h0AAA, 9'h155, RD_LAT);
      check(hit_o === 1'b0, "stale tag after clear");
      run_op(OP_COMPARE, 13'h0AAA, 9'h000, RD_LAT);
      check(hit_o === 1'b1, "zero after clear");
      final_report();
   end
endmodule : tag_ctrl_bench
`default_nettype wire
